// ===== shared/qcp_pkg.sv
// package for the quad counter / pwm / capture block: register map,
// field layouts, reset values and encodings.
// assumes a 32-bit avalon-mm register bus and one system clock.
package qcp_pkg;

   // ------------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ------------------------------------------------------------------
   localparam int QCP_ADDR_W = 6;
   localparam logic [5:0] QCP_OFF_CNT_A = 6'h00;
   localparam logic [5:0] QCP_OFF_CNT_B = 6'h04;
   localparam logic [5:0] QCP_OFF_CNT_C = 6'h08;
   localparam logic [5:0] QCP_OFF_CNT_D = 6'h0c;
   localparam logic [5:0] QCP_OFF_CFG1 = 6'h10;
   localparam logic [5:0] QCP_OFF_CFG2 = 6'h14;
   localparam logic [5:0] QCP_OFF_RUN = 6'h18;
   localparam logic [5:0] QCP_OFF_PORTB = 6'h1c;
   localparam logic [5:0] QCP_OFF_STAT = 6'h20;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] QCP_RST_CFG1 = 8'h00;
   localparam logic [7:0] QCP_RST_CFG2 = 8'h00;
   localparam logic [3:0] QCP_RST_RUN = 4'h0;
   localparam logic [1:0] QCP_RST_PORTB = 2'h0;
   localparam logic [7:0] QCP_RST_CNT = 8'h00;

   // ------------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] QCP_EDGE_OFF = 2'h0;
   localparam logic [1:0] QCP_EDGE_RISE = 2'h1;
   localparam logic [1:0] QCP_EDGE_FALL = 2'h2;
   localparam logic [1:0] QCP_EDGE_BOTH = 2'h3;
   localparam logic [1:0] QCP_SRC_PIN_TWO = 2'h0;
   localparam logic [1:0] QCP_SRC_PIN_THREE = 2'h1;
   localparam logic [1:0] QCP_SRC_TAP_32K = 2'h2;
   localparam logic [1:0] QCP_SRC_TAP_1K = 2'h3;
   localparam logic [1:0] QCP_RES_10 = 2'h0;
   localparam logic [1:0] QCP_RES_12 = 2'h1;
   localparam logic [1:0] QCP_RES_14 = 2'h2;
   localparam logic [1:0] QCP_RES_16 = 2'h3;
   localparam logic [15:0] QCP_MASK_8 = 16'h00ff;
   localparam logic [15:0] QCP_MASK_10 = 16'h03ff;
   localparam logic [15:0] QCP_MASK_12 = 16'h0fff;
   localparam logic [15:0] QCP_MASK_14 = 16'h3fff;
   localparam logic [15:0] QCP_MASK_16 = 16'hffff;

   // ------------------------------------------------------------------
   // field layouts (msb first)
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] pwm_select;      // bit 7 second pair, bit 6 first pair
      logic [1:0] chain;           // bit 5 second pair, bit 4 first pair
      logic [3:0] count_direction_up; // bit n = counter n (a..d)
   } qcp_cfg1_t;

   typedef struct packed {
      logic [1:0] capture_source_select; // bits 7:6
      logic [1:0] capture_edge_select;   // bits 5:4
      logic [1:0] pwm_width_second_pair; // bits 3:2
      logic [1:0] pwm_width_first_pair;  // bits 1:0
   } qcp_cfg2_t;

   typedef struct packed {
      logic [1:0] capture_pending; // bits 3:2
      logic [1:0] pwm_level;       // bits 1:0
   } qcp_stat_t;

endpackage

// ===== hw/qcp_counters.sv
// four 8-bit counters, chainable in pairs, with counter, pwm and capture
// modes, behind an avalon-mm slave with one wait state.
// assumes counter clocks, capture sources and pins arrive as levels
// already synchronous to i_clk_sys, and slower than half its rate.
`timescale 1ns/10ps

// What this block does
// - direction bit set counts up, cleared counts down
// - chain bits join a+b and c+d into 16-bit counters
// - chained upper counter follows lower counter's direction bit
// - up mode: at target, irq on falling edge, zero on rising edge
// - down mode: at zero, irq on falling edge, reload on rising edge
// - stop and restart at target or zero may give one extra irq
// - pwm select replaces port b bit 0 or bit 1 with pwm output
// - pwm counters always count down; hardware masks off their direction bit
// - pwm counters raise no interrupts or events
// - pwm counter wraps to 0xff, or to the width mask (0xffff down to 0x03ff) when chained
// - pwm low while count above code, high while at or below
// - unchained pwm always has 8-bit resolution
// - chained pwm width field picks 16, 14, 12 or 10 bits
// - code above resolution maximum keeps pwm output high
// - pwm period is two to the resolution counter clocks
// - capture mode: a/b reads return shadows, irq on shadow update
// - capture counters count either way and wrap circularly
// - capture source: 1k tap, 32k tap, pin three, pin two
// - capture edge: off, rising, falling, both
// - each counter detects capture independently, lagging one or two edges
// - stopped counter holds its value and ignores clock edges
// - counter mode write sets compare and resets or loads count
module qcp_counters (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // avalon-mm slave
   input wire logic [qcp_pkg::QCP_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // counter clocks, a..d
   input wire logic [3:0] i_cnt_clk,
   // capture sources
   input wire logic i_port_a_pin_two,
   input wire logic i_port_a_pin_three,
   input wire logic i_tap_32k,
   input wire logic i_tap_1k,
   // port b bits 0 and 1 after pwm override
   output logic [1:0] o_port_b_out,
   // counter_a_irq .. counter_d_irq
   output logic [3:0] o_counter_irq
);
   import qcp_pkg::*;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [15:0] qcp_step(input logic [15:0] v,
         input logic [15:0] tgt, input logic [15:0] mask,
         input logic up, input logic reload);
      logic [15:0] r;
      r = 16'h0000;
      if (reload) begin
         r = up ? 16'h0000 : tgt;
      end else if (up) begin
         r = (v + 16'h0001) & mask;
      end else begin
         r = (v - 16'h0001) & mask;
      end
      return r;
   endfunction

   function automatic logic qcp_hit(input logic [15:0] v,
         input logic [15:0] tgt, input logic up);
      return up ? (v == tgt) : (v == 16'h0000);
   endfunction

   function automatic logic [15:0] qcp_pwm_mask(input logic [1:0] width);
      logic [15:0] m;
      m = QCP_MASK_16;
      unique case (width)
         QCP_RES_10: m = QCP_MASK_10;
         QCP_RES_12: m = QCP_MASK_12;
         QCP_RES_14: m = QCP_MASK_14;
         QCP_RES_16: m = QCP_MASK_16;
      endcase
      return m;
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   qcp_cfg1_t cfg1_r;
   qcp_cfg2_t cfg2_r;
   logic [3:0] run_r;
   logic [1:0] portb_r;
   logic [7:0] cnt_r [4];
   logic [7:0] cmp_r [4];
   logic [7:0] shadow_r [2];
   logic [1:0] cap_pend_r;
   logic [3:0] clk_prev_r;
   logic src_prev_r;
   logic waitreq_r;
   logic [31:0] rdata_r;
   logic [1:0] port_b_r;
   logic [3:0] irq_r;

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   logic req;
   logic wr_take;
   logic lane0;
   logic cnt_wr;
   logic [1:0] wr_idx;

   // first cycle of a request raises nothing, second ends the wait
   assign req = i_avs_read | i_avs_write;
   assign wr_take = i_avs_write & ~waitreq_r;
   assign lane0 = i_avs_byteenable[0];
   assign cnt_wr = wr_take & lane0 & (i_avs_address[5:4] == 2'b00) &
      (i_avs_address[1:0] == 2'b00);
   assign wr_idx = i_avs_address[3:2];

   // ------------------------------------------------------------------
   // per-counter mode and next values
   // ------------------------------------------------------------------
   logic [3:0] rise;
   logic [3:0] fall;
   logic [3:0] eff_rise;
   logic [3:0] eff_fall;
   logic [3:0] eff_run;
   logic [3:0] up;
   logic [3:0] is_pwm;
   logic [3:0] is_cap;
   logic [3:0] cnt_mode;
   logic [3:0] cnt_irq;
   logic [15:0] single_nxt [4];
   logic [15:0] pair_nxt [2];
   logic [1:0] pwm_lvl;
   logic cap_src;
   logic cap_evt;
   logic [1:0] cap_take;

   assign rise = i_cnt_clk & ~clk_prev_r;
   assign fall = ~i_cnt_clk & clk_prev_r;

   always_comb begin
      logic [15:0] v16;
      logic [15:0] t16;
      logic [15:0] m16;
      logic [15:0] code16;
      logic [15:0] vs;
      logic ch;
      logic pwm_on;
      logic cap_on;
      int lo;
      int hi;
      v16 = 16'h0000;
      t16 = 16'h0000;
      m16 = 16'h0000;
      code16 = 16'h0000;
      vs = 16'h0000;
      ch = 1'b0;
      pwm_on = 1'b0;
      cap_on = 1'b0;
      lo = 0;
      hi = 0;
      eff_rise = '0;
      eff_fall = '0;
      eff_run = '0;
      up = '0;
      is_pwm = '0;
      is_cap = '0;
      cnt_mode = '0;
      cnt_irq = '0;
      pwm_lvl = '0;
      for (int i = 0; i < 4; i++) begin
         single_nxt[i] = 16'h0000;
      end
      for (int p = 0; p < 2; p++) begin
         lo = 2 * p;
         hi = 2 * p + 1;
         ch = cfg1_r.chain[p];
         pwm_on = cfg1_r.pwm_select[p];
         cap_on = (p == 0) && (cfg2_r.capture_edge_select != QCP_EDGE_OFF);
         is_pwm[lo] = pwm_on;
         is_pwm[hi] = pwm_on & ch;
         is_cap[lo] = cap_on & ~pwm_on;
         is_cap[hi] = cap_on & ~(pwm_on & ch);
         up[lo] = cfg1_r.count_direction_up[lo] & ~pwm_on;
         up[hi] = ch ? up[lo] : cfg1_r.count_direction_up[hi];
         // chained upper byte runs off the lower counter's clock and run
         eff_rise[lo] = rise[lo];
         eff_fall[lo] = fall[lo];
         eff_run[lo] = run_r[lo];
         eff_rise[hi] = ch ? rise[lo] : rise[hi];
         eff_fall[hi] = ch ? fall[lo] : fall[hi];
         eff_run[hi] = ch ? run_r[lo] : run_r[hi];
         cnt_mode[lo] = ~is_pwm[lo] & ~is_cap[lo];
         cnt_mode[hi] = ~is_pwm[hi] & ~is_cap[hi];
         // 16-bit view of the pair
         v16 = {cnt_r[hi], cnt_r[lo]};
         t16 = {cmp_r[hi], cmp_r[lo]};
         m16 = is_pwm[lo] ? qcp_pwm_mask(p == 0 ?
            cfg2_r.pwm_width_first_pair :
            cfg2_r.pwm_width_second_pair) : QCP_MASK_16;
         pair_nxt[p] = qcp_step(v16, t16, m16, up[lo],
            cnt_mode[lo] & qcp_hit(v16, t16, up[lo]));
         for (int k = 0; k < 2; k++) begin
            vs = {8'h00, cnt_r[lo + k]};
            single_nxt[lo + k] = qcp_step(vs, {8'h00, cmp_r[lo + k]},
               QCP_MASK_8, up[lo + k], cnt_mode[lo + k] &
               qcp_hit(vs, {8'h00, cmp_r[lo + k]}, up[lo + k]));
            // a restart while parked on the hit value fires once more
            cnt_irq[lo + k] = ~ch & cnt_mode[lo + k] & eff_fall[lo + k] &
               eff_run[lo + k] &
               qcp_hit(vs, {8'h00, cmp_r[lo + k]}, up[lo + k]);
         end
         if (ch) begin
            cnt_irq[lo] = cnt_mode[lo] & eff_fall[lo] & eff_run[lo] &
               qcp_hit(v16, t16, up[lo]);
            cnt_irq[hi] = 1'b0;
         end
         // pwm compare; an out-of-range code leaves the output high
         code16 = ch ? t16 : {8'h00, cmp_r[lo]};
         vs = ch ? (v16 & m16) : {8'h00, cnt_r[lo]};
         pwm_lvl[p] = (vs <= code16);
      end
   end

   // ------------------------------------------------------------------
   // capture condition
   // ------------------------------------------------------------------
   always_comb begin
      cap_src = i_port_a_pin_two;
      unique case (cfg2_r.capture_source_select)
         QCP_SRC_PIN_TWO: cap_src = i_port_a_pin_two;
         QCP_SRC_PIN_THREE: cap_src = i_port_a_pin_three;
         QCP_SRC_TAP_32K: cap_src = i_tap_32k;
         QCP_SRC_TAP_1K: cap_src = i_tap_1k;
      endcase
   end

   always_comb begin
      cap_evt = 1'b0;
      unique case (cfg2_r.capture_edge_select)
         QCP_EDGE_OFF: cap_evt = 1'b0;
         QCP_EDGE_RISE: cap_evt = cap_src & ~src_prev_r;
         QCP_EDGE_FALL: cap_evt = ~cap_src & src_prev_r;
         QCP_EDGE_BOTH: cap_evt = cap_src ^ src_prev_r;
      endcase
   end

   // each counter latches on its own next counting edge
   assign cap_take = cap_pend_r & is_cap[1:0] & eff_rise[1:0] & eff_run[1:0];

   // ------------------------------------------------------------------
   // edge history
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         clk_prev_r <= 4'h0;
         src_prev_r <= 1'b0;
      end else begin
         clk_prev_r <= i_cnt_clk;
         src_prev_r <= cap_src;
      end
   end

   // ------------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         cfg1_r <= QCP_RST_CFG1;
         cfg2_r <= QCP_RST_CFG2;
         run_r <= QCP_RST_RUN;
         portb_r <= QCP_RST_PORTB;
      end else if (wr_take && lane0) begin
         unique case (i_avs_address)
            QCP_OFF_CFG1: cfg1_r <= i_avs_writedata[7:0];
            QCP_OFF_CFG2: cfg2_r <= i_avs_writedata[7:0];
            QCP_OFF_RUN: run_r <= i_avs_writedata[3:0];
            QCP_OFF_PORTB: portb_r <= i_avs_writedata[1:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // counters and compare values
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         for (int i = 0; i < 4; i++) begin
            cnt_r[i] <= QCP_RST_CNT;
            cmp_r[i] <= QCP_RST_CNT;
         end
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (cfg1_r.chain[p]) begin
               if (rise[2 * p] && run_r[2 * p]) begin
                  cnt_r[2 * p] <= pair_nxt[p][7:0];
                  cnt_r[2 * p + 1] <= pair_nxt[p][15:8];
               end
            end else begin
               for (int k = 0; k < 2; k++) begin
                  if (rise[2 * p + k] && run_r[2 * p + k]) begin
                     cnt_r[2 * p + k] <= single_nxt[2 * p + k][7:0];
                  end
               end
            end
         end
         // a write wins over a counting edge in the same cycle
         if (cnt_wr) begin
            cmp_r[wr_idx] <= i_avs_writedata[7:0];
            if (cnt_mode[wr_idx]) begin
               cnt_r[wr_idx] <= up[wr_idx] ? 8'h00 : i_avs_writedata[7:0];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // capture shadows
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         cap_pend_r <= 2'h0;
         shadow_r[0] <= QCP_RST_CNT;
         shadow_r[1] <= QCP_RST_CNT;
      end else begin
         // a new condition in the taking cycle stays pending
         cap_pend_r <= (cap_pend_r & ~cap_take) | {2{cap_evt}};
         for (int k = 0; k < 2; k++) begin
            if (cap_take[k]) begin
               shadow_r[k] <= cnt_r[k];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // outputs: irq pulses and port b
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         irq_r <= 4'h0;
      end else begin
         // pwm counters never reach cnt_irq
         irq_r <= cnt_irq | {2'b00, cap_take};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         port_b_r <= QCP_RST_PORTB;
      end else begin
         for (int p = 0; p < 2; p++) begin
            port_b_r[p] <= cfg1_r.pwm_select[p] ? pwm_lvl[p] : portb_r[p];
         end
      end
   end

   // ------------------------------------------------------------------
   // avalon read path and wait state
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         waitreq_r <= 1'b1;
      end else begin
         waitreq_r <= ~(req & waitreq_r);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      qcp_stat_t st;
      if (!i_reset_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (i_avs_read && waitreq_r) begin
         st.capture_pending = cap_pend_r;
         st.pwm_level = pwm_lvl;
         unique case (i_avs_address)
            QCP_OFF_CNT_A: rdata_r <= {24'h0, is_cap[0] ? shadow_r[0] : cnt_r[0]};
            QCP_OFF_CNT_B: rdata_r <= {24'h0, is_cap[1] ? shadow_r[1] : cnt_r[1]};
            QCP_OFF_CNT_C: rdata_r <= {24'h0, cnt_r[2]};
            QCP_OFF_CNT_D: rdata_r <= {24'h0, cnt_r[3]};
            QCP_OFF_CFG1: rdata_r <= {24'h0, cfg1_r};
            QCP_OFF_CFG2: rdata_r <= {24'h0, cfg2_r};
            QCP_OFF_RUN: rdata_r <= {28'h0, run_r};
            QCP_OFF_PORTB: rdata_r <= {30'h0, portb_r};
            QCP_OFF_STAT: rdata_r <= {28'h0, st};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign o_avs_readdata = rdata_r;
   assign o_avs_waitrequest = waitreq_r;
   assign o_port_b_out = port_b_r;
   assign o_counter_irq = irq_r;

endmodule

// ===== tb/qcp_counters_sva.sv
// checker: bus timing, irq pulses and port b outputs of qcp_counters
// assumes a bind to the top module, one clock domain
`timescale 1ns/10ps
module qcp_counters_sva (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic [3:0] i_cnt_clk,
   input wire logic [1:0] o_port_b_out,
   input wire logic [3:0] o_counter_irq
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   logic req;
   assign req = i_avs_read | i_avs_write;
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_wait_one;
      req && ($past(!o_avs_waitrequest) || !$past(req)) |->
         o_avs_waitrequest ##1 !o_avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("wait state count wrong");
   property p_low_one;
      !o_avs_waitrequest |=> o_avs_waitrequest;
   endproperty
   a_low_one: assert property (p_low_one)
      else $error("waitrequest low too long");
   property p_idle_wait;
      !req && $past(!req) |-> o_avs_waitrequest;
   endproperty
   a_idle_wait: assert property (p_idle_wait)
      else $error("waitrequest low while idle");
   property p_rd_high;
      !o_avs_waitrequest && i_avs_read |-> o_avs_readdata[31:8] == 24'h0;
   endproperty
   a_rd_high: assert property (p_rd_high)
      else $error("read data upper bits set");
   property p_rd_hold;
      !i_avs_read && $past(!i_avs_read) |-> $stable(o_avs_readdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed without read");
   property p_irq_pulse;
      (o_counter_irq & $past(o_counter_irq)) == 4'h0;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("irq longer than one cycle");
   // irq needs a counter clock edge shortly before
   property p_quiet_irq;
      $stable(i_cnt_clk) [*5] |-> o_counter_irq == 4'h0;
   endproperty
   a_quiet_irq: assert property (p_quiet_irq)
      else $error("irq without counter clock");
   property p_portb_hold;
      (!i_avs_write && $stable(i_cnt_clk)) [*4] |-> $stable(o_port_b_out);
   endproperty
   a_portb_hold: assert property (p_portb_hold)
      else $error("port b changed without cause");
   c_irq_a: cover property (o_counter_irq[0]);
   c_irq_c: cover property (o_counter_irq[2]);
   c_pwm: cover property ($rose(o_port_b_out[0]));
endmodule

// ===== tb/qcp_far_side.sv
// far side model: counter clock source and irq tally per counter
// assumes one request pulse starts one counter clock period
`timescale 1ns/10ps
module qcp_far_side (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_req,
   input wire logic [3:0] i_mask,
   input wire logic [3:0] i_irq,
   output logic [3:0] o_cnt_clk,
   output logic o_busy,
   output logic [31:0] o_irq_count
);
   logic [2:0] phase_r;
   logic [3:0] mask_r;
   // clock high 3 cycles, low 4; stands low between periods
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         phase_r <= 3'h0;
         mask_r <= 4'h0;
      end else if (i_req && phase_r == 3'h0) begin
         phase_r <= 3'h1;
         mask_r <= i_mask;
      end else if (phase_r != 3'h0) begin
         phase_r <= phase_r + 3'h1;
      end
   end
   assign o_cnt_clk = (phase_r != 3'h0 && phase_r < 3'h4) ? mask_r : 4'h0;
   assign o_busy = phase_r != 3'h0;
   always_ff @(posedge i_clk_sys) begin
      for (int i = 0; i < 4; i++) begin
         if (!i_reset_n) begin
            o_irq_count[i*8 +: 8] <= 8'h00;
         end else if (i_irq[i]) begin
            o_irq_count[i*8 +: 8] <= o_irq_count[i*8 +: 8] + 8'h01;
         end
      end
   end
endmodule

// ===== tb/qcp_counters_tb_top.sv
// testbench: register sequences against the counters, pwm and capture
// assumes qcp_pkg, qcp_counters, the far side model and the checker
`timescale 1ns/10ps
module qcp_counters_tb_top;
   import qcp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wreq;
   logic [3:0] cclk, irq;
   logic [3:0] mask = 4'h0;
   logic req = 1'b0;
   logic pin2 = 1'b0;
   logic busy;
   logic [1:0] pb;
   logic [31:0] icnt;
   logic [7:0] q;
   int bad_count = 0;
   int checked = 0;
   initial forever #20 clk = ~clk;
   qcp_counters i_qcp_counters (.i_clk_sys(clk), .i_reset_n(rst_n),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_cnt_clk(cclk),
      .i_port_a_pin_two(pin2), .i_port_a_pin_three(1'b0),
      .i_tap_32k(1'b0), .i_tap_1k(1'b0), .o_port_b_out(pb),
      .o_counter_irq(irq));
   qcp_far_side i_qcp_far_side (.i_clk_sys(clk), .i_reset_n(rst_n),
      .i_req(req), .i_mask(mask), .i_irq(irq), .o_cnt_clk(cclk),
      .o_busy(busy), .o_irq_count(icnt));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task chk(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= {24'h0, d};
      // no cycle count assumed; loops until waitrequest drops, bounded only by the hang guard
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task rd_chk(input string what, input logic [5:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(what, {24'h0, q}, {24'h0, e});
   endtask
   task pulse(input int n, input logic [3:0] m);
      int k;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         req <= 1'b1;
         mask <= m;
         @(posedge clk);
         req <= 1'b0;
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (busy !== 1'b0 && k < 20);
         if (busy !== 1'b0) bad_count++;
      end
   endtask
   task test_done;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // hang guard, nearly four times the expected run
   initial begin
      #800000;
      bad_count++;
      test_done();
   end
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      int hi;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("cfg1", QCP_OFF_CFG1, QCP_RST_CFG1);
      rd_chk("cnt a", QCP_OFF_CNT_A, QCP_RST_CNT);
      rd_chk("unmapped", 6'h24, 8'h00);
      $display("test reset done");
      bus(1'b1, QCP_OFF_CFG1, 8'h01);
      bus(1'b1, QCP_OFF_CNT_A, 8'h02);
      bus(1'b1, QCP_OFF_RUN, 8'h01);
      pulse(2, 4'h1);
      chk("irq a", icnt[7:0], 8'h01);
      rd_chk("cnt a", QCP_OFF_CNT_A, 8'h02);
      pulse(1, 4'h1);
      rd_chk("cnt a", QCP_OFF_CNT_A, 8'h00);
      bus(1'b1, QCP_OFF_RUN, 8'h00);
      pulse(3, 4'h1);
      rd_chk("cnt a", QCP_OFF_CNT_A, 8'h00);
      chk("irq a", icnt[7:0], 8'h01);
      $display("test up count done");
      // d's own direction bit set, must be ignored
      bus(1'b1, QCP_OFF_CFG1, 8'h28);
      bus(1'b1, QCP_OFF_CNT_C, 8'h01);
      bus(1'b1, QCP_OFF_CNT_D, 8'h01);
      bus(1'b1, QCP_OFF_RUN, 8'h04);
      pulse(2, 4'h4);
      rd_chk("cnt c", QCP_OFF_CNT_C, 8'hff);
      rd_chk("cnt d", QCP_OFF_CNT_D, 8'h00);
      pulse(255, 4'h4);
      chk("irq c d", icnt[31:16], 16'h0001);
      pulse(1, 4'h4);
      rd_chk("cnt d", QCP_OFF_CNT_D, 8'h01);
      $display("test chained down done");
      bus(1'b1, QCP_OFF_CFG1, 8'h40);
      bus(1'b1, QCP_OFF_CFG2, 8'h03);
      bus(1'b1, QCP_OFF_CNT_A, 8'h3f);
      bus(1'b1, QCP_OFF_PORTB, 8'h02);
      bus(1'b1, QCP_OFF_RUN, 8'h01);
      hi = 0;
      for (int i = 0; i < 256; i++) begin
         pulse(1, 4'h1);
         hi += (pb[0] === 1'b1);
      end
      chk("pwm high count", hi, 32'h40);
      chk("port b one", {31'h0, pb[1]}, 32'h1);
      chk("irq a", icnt[7:0], 8'h01);
      $display("test pwm done");
      bus(1'b1, QCP_OFF_RUN, 8'h00);
      bus(1'b1, QCP_OFF_CFG1, 8'h03);
      bus(1'b1, QCP_OFF_CFG2, 8'h10);
      bus(1'b1, QCP_OFF_CNT_A, 8'hff);
      bus(1'b1, QCP_OFF_CNT_B, 8'hff);
      bus(1'b1, QCP_OFF_RUN, 8'h03);
      pulse(2, 4'h3);
      pin2 <= 1'b1;
      pulse(3, 4'h3);
      chk("capture irq", icnt[15:0], 16'h0102);
      rd_chk("shadow a", QCP_OFF_CNT_A, 8'h02);
      pulse(2, 4'h3);
      rd_chk("shadow a", QCP_OFF_CNT_A, 8'h02);
      rd_chk("shadow b", QCP_OFF_CNT_B, 8'h02);
      pin2 <= 1'b0;
      pulse(3, 4'h3);
      chk("falling ignored", icnt[15:0], 16'h0102);
      $display("test capture done");
      // count parked at 0xffff, so only a 10-bit view stays under the code
      bus(1'b1, QCP_OFF_PORTB, 8'h00);
      bus(1'b1, QCP_OFF_CFG1, 8'h20);
      bus(1'b1, QCP_OFF_CNT_C, 8'hff);
      bus(1'b1, QCP_OFF_CNT_D, 8'hff);
      bus(1'b1, QCP_OFF_CFG1, 8'ha0);
      bus(1'b1, QCP_OFF_CNT_C, 8'h00);
      bus(1'b1, QCP_OFF_CNT_D, 8'h04);
      bus(1'b1, QCP_OFF_RUN, 8'h04);
      pulse(1, 4'h4);
      chk("pwm over range", {31'h0, pb[1]}, 32'h1);
      bus(1'b1, QCP_OFF_CNT_D, 8'h00);
      pulse(1, 4'h4);
      chk("pwm chained low", {31'h0, pb[1]}, 32'h0);
      $display("test chained pwm done");
      test_done();
   end
endmodule
bind qcp_counters qcp_counters_sva i_qcp_counters_sva (
   .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_cnt_clk(i_cnt_clk),
   .o_port_b_out(o_port_b_out), .o_counter_irq(o_counter_irq));
